// File: logic/tsr_i2c_top_regs.v
/*
 * Bus target for the top-system registers: address match, byte
 * acknowledge, pointer-addressed writes and reads, continuous
 * reads, fault event flags and the two reset classes.
 * Assumes synchronous pins, an open-drain data line resolved
 * outside, and fault levels already debounced.
 */
`timescale 1ns/10ps
`include "tsr_map.vh"

module tsr_i2c_top_regs #(
    parameter [7:0] CHIP_IDENTIFIER_VALUE = 8'h5a, // Arbitrary value
    parameter [3:0] VERSION_VALUE = 4'h0,
    parameter [3:0] PASS_VALUE = 4'h9, // Arbitrary value
    parameter [3:0] TRIM_REV_VALUE = 4'h0
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // Bus pins
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    // Supply and fault monitors
    input wire supply_below_logic_i,
    input wire supply_undervolt_i,
    input wire supply_overvolt_i,
    input wire die_overheat_i,
    input wire powerup_fail_i,
    // Register outputs
    output wire [7:0] monitor_ctrl_o,
    output wire [7:0] bus_cfg_o,
    output wire [7:0] ship_ctrl_o,
    // Reset and event status
    output wire soft_reset_o,
    output wire fault_reset_o,
    output wire event_pending_o
);

////////////////////////////////////////////////////////////////////////
// States and declarations

localparam [2:0] ST_IDLE = 3'd0;
localparam [2:0] ST_RX_BYTE = 3'd1;
localparam [2:0] ST_RX_ACK = 3'd2;
localparam [2:0] ST_TX_BYTE = 3'd3;
localparam [2:0] ST_TX_ACK = 3'd4;
localparam [2:0] ST_WAIT_STOP = 3'd5;

// Byte position within a transfer
localparam [1:0] BY_ADDR = 2'd0;
localparam [1:0] BY_PTR = 2'd1;
localparam [1:0] BY_DATA = 2'd2;

reg [2:0] state_ff;
reg [3:0] bit_cnt_ff;
reg [1:0] byte_idx_ff;
reg [7:0] shift_ff;
reg [7:0] tx_ff;
reg [7:0] ptr_ff;
reg ptr_set_ff;
reg rw_ff;
reg oe_ff;
reg wr_stb_ff;
reg [7:0] wr_addr_ff;
reg [7:0] wr_data_ff;

reg [7:0] mask_ff;
reg [7:0] ctrl_ff;
reg [7:0] bus_cfg_ff;
reg [7:0] soft_rst_ff;
reg [7:0] ship_ff;
reg pending_ff;

reg [7:0] rd_data;
wire start_c;
wire stop_c;
wire scl_rise;
wire scl_fall;
wire s_rst;
wire o_rst;
wire tx_load;
wire rd_clr;
wire [3:0] flags;
wire [7:0] flags_byte;
wire [7:0] mask_used;
wire addr_hit;

////////////////////////////////////////////////////////////////////////
// Reset classes

// Supply-loss class also covers the system reset
assign s_rst = rst_i | supply_below_logic_i;

// Fault class: supply loss, lockouts, overheat or soft reset
assign o_rst = s_rst | supply_undervolt_i | supply_overvolt_i
             | die_overheat_i | soft_reset_o;

////////////////////////////////////////////////////////////////////////
// Bus conditions and fault flags

tsr_bus_cond u_bus_cond (
    .ref_clk_i(ref_clk_i),
    .rst_i(s_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .start_o(start_c),
    .stop_o(stop_c),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall)
);

// Flags are supply-loss class, so they survive the fault they report
tsr_fault_events #(
    .WIDTH(4)
) u_fault_events (
    .ref_clk_i(ref_clk_i),
    .rst_i(s_rst),
    .fault_i({die_overheat_i, supply_overvolt_i,
              supply_undervolt_i, powerup_fail_i}),
    .clear_i(rd_clr),
    .flags_o(flags)
);

// Flag byte in register layout, spare bits read zero
assign flags_byte = {1'b0, flags[3], flags[2], flags[1],
                     3'b000, flags[0]};

////////////////////////////////////////////////////////////////////////
// Read multiplexer

// Unmapped offsets read zero so continuous reads can run past the map
always @* begin
    case (ptr_ff)
        `TSR_ADR_CHIP_IDENTIFIER: rd_data = CHIP_IDENTIFIER_VALUE;
        `TSR_ADR_SI_REV: rd_data = {VERSION_VALUE, PASS_VALUE};
        `TSR_ADR_TRIM_REV: rd_data = {4'h0, TRIM_REV_VALUE};
        `TSR_ADR_FLAGS: rd_data = flags_byte;
        `TSR_ADR_MASK: rd_data = mask_ff;
        `TSR_ADR_CTRL: rd_data = ctrl_ff;
        `TSR_ADR_BUS_CFG: rd_data = bus_cfg_ff;
        `TSR_ADR_SOFT_RST: rd_data = soft_rst_ff;
        `TSR_ADR_SHIP: rd_data = ship_ff;
        default: rd_data = 8'h00;
    endcase
end

// A transmit byte is loaded at the clock fall ending an ack slot
assign tx_load = scl_fall & ((state_ff == ST_RX_ACK & rw_ff)
               | state_ff == ST_TX_ACK);

// Reading the flag register clears it at the load edge
assign rd_clr = tx_load & (ptr_ff == `TSR_ADR_FLAGS);

// Address byte matches our bus address
assign addr_hit = (shift_ff[7:1] == `TSR_TARGET_ADDR);

////////////////////////////////////////////////////////////////////////
// Bus target state machine

// Stop and start override any state; no byte count limit exists
always @(posedge ref_clk_i) begin
    if (s_rst) begin
        state_ff <= ST_IDLE;
        bit_cnt_ff <= 4'h0;
        byte_idx_ff <= BY_ADDR;
        shift_ff <= 8'h00;
        tx_ff <= 8'h00;
        ptr_ff <= 8'h00;
        ptr_set_ff <= 1'b0;
        rw_ff <= 1'b0;
        oe_ff <= 1'b0;
        wr_stb_ff <= 1'b0;
        wr_addr_ff <= 8'h00;
        wr_data_ff <= 8'h00;
    end else begin
        wr_stb_ff <= 1'b0;
        if (stop_c) begin
            state_ff <= ST_IDLE;
            oe_ff <= 1'b0;
            ptr_set_ff <= 1'b0;
        end else if (start_c) begin
            // Repeated start keeps a pointer set earlier
            state_ff <= ST_RX_BYTE;
            bit_cnt_ff <= 4'h0;
            byte_idx_ff <= BY_ADDR;
            oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_RX_BYTE: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_i};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                        bit_cnt_ff <= 4'h0;
                        if (byte_idx_ff == BY_ADDR) begin
                            if (addr_hit) begin
                                rw_ff <= shift_ff[0];
                                oe_ff <= 1'b1;
                                state_ff <= ST_RX_ACK;
                                byte_idx_ff <= BY_PTR;
                                if (shift_ff[0] && !ptr_set_ff) begin
                                    ptr_ff <= `TSR_ADR_CHIP_IDENTIFIER;
                                end
                            end else begin
                                state_ff <= ST_WAIT_STOP;
                            end
                        end else if (byte_idx_ff == BY_PTR) begin
                            ptr_ff <= shift_ff;
                            ptr_set_ff <= 1'b1;
                            oe_ff <= 1'b1;
                            state_ff <= ST_RX_ACK;
                            byte_idx_ff <= BY_DATA;
                        end else begin
                            wr_stb_ff <= 1'b1;
                            wr_addr_ff <= ptr_ff;
                            wr_data_ff <= shift_ff;
                            ptr_ff <= ptr_ff + 8'h01;
                            oe_ff <= 1'b1;
                            state_ff <= ST_RX_ACK;
                        end
                    end
                end
                ST_RX_ACK: begin
                    // Low held over the whole ack clock high phase
                    if (tx_load) begin
                        tx_ff <= rd_data;
                        oe_ff <= ~rd_data[7];
                        ptr_ff <= ptr_ff + 8'h01;
                        bit_cnt_ff <= 4'h0;
                        state_ff <= ST_TX_BYTE;
                    end else if (scl_fall) begin
                        oe_ff <= 1'b0;
                        state_ff <= ST_RX_BYTE;
                    end
                end
                ST_TX_BYTE: begin
                    // Data changes only after the clock falls
                    if (scl_fall) begin
                        if (bit_cnt_ff == 4'h7) begin
                            oe_ff <= 1'b0;
                            state_ff <= ST_TX_ACK;
                        end else begin
                            tx_ff <= {tx_ff[6:0], 1'b0};
                            oe_ff <= ~tx_ff[6];
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    // Controller's ack is sampled at the clock rise
                    if (scl_rise && sda_i) begin
                        state_ff <= ST_WAIT_STOP;
                    end else if (tx_load) begin
                        tx_ff <= rd_data;
                        oe_ff <= ~rd_data[7];
                        ptr_ff <= ptr_ff + 8'h01;
                        bit_cnt_ff <= 4'h0;
                        state_ff <= ST_TX_BYTE;
                    end
                end
                ST_WAIT_STOP: begin
                    oe_ff <= 1'b0;
                end
                default: begin
                    state_ff <= ST_IDLE;
                    oe_ff <= 1'b0;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Writable registers, fault reset class

// Read-only and read-clear offsets ignore writes
always @(posedge ref_clk_i) begin
    if (o_rst) begin
        mask_ff <= `TSR_RST_MASK;
        ctrl_ff <= `TSR_RST_CTRL;
        bus_cfg_ff <= `TSR_RST_BUS_CFG;
        soft_rst_ff <= `TSR_RST_SOFT_RST;
        ship_ff <= `TSR_RST_SHIP;
    end else if (wr_stb_ff) begin
        case (wr_addr_ff)
            `TSR_ADR_MASK: mask_ff <= wr_data_ff;
            `TSR_ADR_CTRL: ctrl_ff <= wr_data_ff & `TSR_CTRL_WR_MASK;
            `TSR_ADR_BUS_CFG: bus_cfg_ff <= wr_data_ff;
            `TSR_ADR_SOFT_RST: soft_rst_ff <= wr_data_ff;
            `TSR_ADR_SHIP: ship_ff <= wr_data_ff;
            default: ship_ff <= ship_ff;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Masked event summary

// Mask bit 1 hides the matching flag
assign mask_used = {1'b0, mask_ff[`TSR_BIT_OVERHEAT],
                    mask_ff[`TSR_BIT_OVERVOLT],
                    mask_ff[`TSR_BIT_UNDERVOLT],
                    3'b000, mask_ff[`TSR_BIT_PWRUP]};

always @(posedge ref_clk_i) begin
    if (s_rst) begin
        pending_ff <= 1'b0;
    end else begin
        pending_ff <= |(flags_byte & ~mask_used);
    end
end

////////////////////////////////////////////////////////////////////////
// Outputs

// Open drain: only ever pulls low
assign sda_o = 1'b0;
assign sda_oe_o = oe_ff;
assign monitor_ctrl_o = ctrl_ff;
assign bus_cfg_o = bus_cfg_ff;
assign ship_ctrl_o = ship_ff;
// Nonzero write resets its own register, so this lasts one cycle
assign soft_reset_o = |soft_rst_ff;
assign fault_reset_o = o_rst;
assign event_pending_o = pending_ff;

endmodule // tsr_i2c_top_regs

// File: logic/tsr_map.vh
/*
 * Constants for the top-system register target: bus address,
 * register offsets, reset values and flag bit positions.
 * Assumes it is included by bare name from the logic/ files.
 */
`ifndef TSR_MAP_VH
`define TSR_MAP_VH

// 7-bit bus address of the target
`define TSR_TARGET_ADDR 7'h6b

// Register offsets
`define TSR_ADR_CHIP_IDENTIFIER 8'h00
`define TSR_ADR_SI_REV 8'h01
`define TSR_ADR_TRIM_REV 8'h02
`define TSR_ADR_FLAGS 8'h03
`define TSR_ADR_MASK 8'h04
`define TSR_ADR_CTRL 8'h05
`define TSR_ADR_BUS_CFG 8'h40
`define TSR_ADR_SOFT_RST 8'h50
`define TSR_ADR_SHIP 8'h51

// Reset values
`define TSR_RST_FLAGS 4'h0
`define TSR_RST_MASK 8'hfe
`define TSR_RST_CTRL 8'h01
`define TSR_RST_BUS_CFG 8'h00
`define TSR_RST_SOFT_RST 8'h00
`define TSR_RST_SHIP 8'h00

// Writable bits of the monitor control register
`define TSR_CTRL_WR_MASK 8'h7f

// Flag bit positions in the event and mask registers
`define TSR_BIT_OVERHEAT 6
`define TSR_BIT_OVERVOLT 5
`define TSR_BIT_UNDERVOLT 4
`define TSR_BIT_PWRUP 0

`endif

// File: logic/tsr_bus_cond.v
/*
 * Bus condition detector: start, stop and clock edges from the
 * sampled clock and data pins.
 * Assumes scl_i and sda_i are already synchronous to ref_clk_i.
 */
`timescale 1ns/10ps

module tsr_bus_cond (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // Bus pins
    input wire scl_i,
    input wire sda_i,
    // Conditions, one-cycle pulses
    output wire start_o,
    output wire stop_o,
    output wire scl_rise_o,
    output wire scl_fall_o
);

reg scl_ff;
reg sda_ff;

////////////////////////////////////////////////////////////////////////
// Previous pin levels; idle bus is high
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        scl_ff <= 1'b1;
        sda_ff <= 1'b1;
    end else begin
        scl_ff <= scl_i;
        sda_ff <= sda_i;
    end
end

// Data edges while clock stays high are bus conditions
assign start_o = scl_ff & scl_i & sda_ff & ~sda_i;
assign stop_o = scl_ff & scl_i & ~sda_ff & sda_i;
assign scl_rise_o = ~scl_ff & scl_i;
assign scl_fall_o = scl_ff & ~scl_i;

endmodule // tsr_bus_cond

// File: logic/tsr_fault_events.v
/*
 * Sticky fault event flags, set on entry into each fault level.
 * Assumes fault levels are synchronous and clear_i is a pulse.
 */
`timescale 1ns/10ps

module tsr_fault_events #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // Fault levels and clear
    input wire [WIDTH-1:0] fault_i,
    input wire clear_i,
    // Sticky flags
    output wire [WIDTH-1:0] flags_o
);

reg [WIDTH-1:0] level_ff;
reg [WIDTH-1:0] flags_ff;
wire [WIDTH-1:0] entry;

// Only the entry edge counts, a held fault sets once
assign entry = fault_i & ~level_ff;

////////////////////////////////////////////////////////////////////////
// Set wins over a clear in the same cycle so no event is lost
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        level_ff <= {WIDTH{1'b0}};
        flags_ff <= {WIDTH{1'b0}};
    end else begin
        level_ff <= fault_i;
        flags_ff <= (clear_i ? {WIDTH{1'b0}} : flags_ff) | entry;
    end
end

assign flags_o = flags_ff;

endmodule // tsr_fault_events

// File: test/tsr_i2c_top_regs_assertions.sv
/* Checker for the top-system register target, bound to its top.
   Assumes one clock domain with a synchronous active-high reset. */
`timescale 1ns/10ps
module tsr_regs_chk (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // Bus pins
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o,
    // Monitors
    input wire supply_below_logic_i,
    input wire supply_undervolt_i,
    input wire supply_overvolt_i,
    input wire die_overheat_i,
    input wire powerup_fail_i,
    // Registers and status
    input wire [7:0] monitor_ctrl_o,
    input wire [7:0] bus_cfg_o,
    input wire [7:0] ship_ctrl_o,
    input wire soft_reset_o,
    input wire fault_reset_o,
    input wire event_pending_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    // Clock seen high on three samples running
    sequence scl_held_high;
        scl_i [*3];
    endsequence
    // Soft reset stands a single cycle
    sequence soft_once;
        soft_reset_o ##1 !soft_reset_o;
    endsequence
    // Control registers back at reset values
    sequence regs_back;
        ##1 (monitor_ctrl_o == 8'h01 && bus_cfg_o == 8'h00 && ship_ctrl_o == 8'h00);
    endsequence
    chk_hold_high: assert property (scl_held_high |-> $stable(sda_oe_o))
        else $error("data drive moved while clock high");
    chk_drive_timing: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i) && $past(scl_i, 2))
        else $error("data drive not one cycle after clock fall");
    chk_release_low: assert property ($fell(sda_oe_o) |-> !scl_i)
        else $error("data released while clock high");
    chk_stop_release: assert property (scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe_o)
        else $error("data driven after stop");
    chk_fault_source: assert property
        ((supply_below_logic_i || supply_undervolt_i || supply_overvolt_i || die_overheat_i) |-> fault_reset_o)
        else $error("fault reset missing");
    chk_regs_restore: assert property (fault_reset_o |-> regs_back)
        else $error("registers not reset by fault");
    chk_soft_pulse: assert property ($rose(soft_reset_o) |-> soft_once)
        else $error("soft reset not a single pulse");
    // Writes land only in the clock-low phase that opens the acknowledge slot
    chk_write_slot: assert property
        (($changed(bus_cfg_o) || $changed(ship_ctrl_o)) && !$past(fault_reset_o) |-> !scl_i && !$past(scl_i))
        else $error("register changed outside write slot");
endmodule // tsr_regs_chk

bind tsr_i2c_top_regs tsr_regs_chk chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .supply_below_logic_i(supply_below_logic_i),
    .supply_undervolt_i(supply_undervolt_i), .supply_overvolt_i(supply_overvolt_i),
    .die_overheat_i(die_overheat_i), .powerup_fail_i(powerup_fail_i), .monitor_ctrl_o(monitor_ctrl_o),
    .bus_cfg_o(bus_cfg_o), .ship_ctrl_o(ship_ctrl_o), .soft_reset_o(soft_reset_o),
    .fault_reset_o(fault_reset_o), .event_pending_o(event_pending_o));

// File: test/tsr_host_model.sv
/* Bus controller model: drives the clock and pulls data low.
   Assumes the bench resolves a pulled-up data wire. */
`timescale 1ns/10ps
module tsr_host_model (
    // Clock
    input wire ref_clk_i,
    // Bus
    input wire sda_i,
    output reg scl_o,
    output reg sda_low_o
);
    // Idle bus: clock stands high, data released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    ////////////////////////////////////////
    // Step just off the edge so the target never races us
    task tick(input integer n);
        begin
            repeat (n) @(posedge ref_clk_i);
            #1;
        end
    endtask
    // Also serves as repeated start
    task start;
        begin
            tick(2);
            sda_low_o = 1'b0;
            tick(3);
            scl_o = 1'b1;
            tick(4);
            sda_low_o = 1'b1;
            tick(4);
            scl_o = 1'b0;
        end
    endtask
    task stop;
        begin
            tick(2);
            sda_low_o = 1'b1;
            tick(3);
            scl_o = 1'b1;
            tick(4);
            sda_low_o = 1'b0;
            tick(4);
        end
    endtask
    // Data moves only while the clock is low
    task bit_xfer(input b, output s);
        begin
            tick(2);
            sda_low_o = ~b;
            tick(3);
            scl_o = 1'b1;
            tick(4);
            s = sda_i;
            scl_o = 1'b0;
        end
    endtask
    // Eight bits first to last, then the extra acknowledge clock
    task xfer_byte(input [7:0] tx, input ai, output [7:0] rx, output a);
        integer i;
        reg s;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_xfer(tx[i], s);
                rx[i] = s;
            end
            bit_xfer(ai, a);
        end
    endtask
endmodule // tsr_host_model

// File: test/test_i2c_top_system_registers.sv
/* Self-checking bench for the top-system register target.
   Assumes the host model drives the bus and the checker is bound. */
`timescale 1ns/10ps
module test_i2c_top_system_registers;
    reg ref_clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [4:0] flt = 5'h00; // Supply loss, undervolt, overvolt, overheat, power-up
    reg [31:0] rnd = 32'hb32198e1;
    reg [8:0] exp_q[$];
    reg [8:0] got;
    reg [7:0] a;
    reg [7:0] m;
    event got_ev;
    integer n_errors = 0;
    integer num_checks = 0;
    integer i;
    wire scl, host_low, sda_oe, sda_o;
    wire [7:0] ctrl, cfg, ship;
    wire soft_rst, flt_rst, pend;
    // Open-drain data line with pull-up
    wire sda = ~(host_low | sda_oe);

    tsr_i2c_top_regs dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .supply_below_logic_i(flt[4]), .supply_undervolt_i(flt[3]),
        .supply_overvolt_i(flt[2]), .die_overheat_i(flt[1]), .powerup_fail_i(flt[0]), .monitor_ctrl_o(ctrl),
        .bus_cfg_o(cfg), .ship_ctrl_o(ship), .soft_reset_o(soft_rst), .fault_reset_o(flt_rst),
        .event_pending_o(pend));
    tsr_host_model host_u (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    ////////////////////////////////////////
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task cyc(input integer n);
        begin
            repeat (n) @(posedge ref_clk_i);
            #1;
        end
    endtask
    task check(input [39:0] nm, input [8:0] seen, input [8:0] want);
        begin
            num_checks = num_checks + 1;
            if (seen !== want) begin
                n_errors = n_errors + 1;
                $display("BAD %0s want %h seen %h", nm, want, seen);
            end
        end
    endtask
    // Note the expected wire byte and acknowledge, then move it
    task xb(input [7:0] tx, input ai, input [8:0] want);
        reg [7:0] rx;
        reg ak;
        begin
            exp_q.push_back(want);
            host_u.xfer_byte(tx, ai, rx, ak);
            got = {ak, rx};
            -> got_ev;
        end
    endtask
    // Oldest note against each byte seen on the wire
    always @(got_ev) begin
        check("byte", got, exp_q.pop_front());
    end
    task wr(input [7:0] ad, input [7:0] d);
        begin
            host_u.start;
            xb(8'hd6, 1'b1, 9'h0d6);
            xb(ad, 1'b1, {1'b0, ad});
            xb(d, 1'b1, {1'b0, d});
            host_u.stop;
        end
    endtask
    task rd(input [7:0] ad, input [7:0] d);
        begin
            host_u.start;
            xb(8'hd6, 1'b1, 9'h0d6);
            xb(ad, 1'b1, {1'b0, ad});
            host_u.start;
            xb(8'hd7, 1'b1, 9'h0d7);
            xb(8'hff, 1'b1, {1'b1, d});
            host_u.stop;
        end
    endtask
    task final_report;
        begin
            $display("checks %0d errors %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // Hang guard
    initial begin
        #900000;
        n_errors = n_errors + 1;
        final_report;
    end
    ////////////////////////////////////////
    initial begin
        cyc(5);
        rst_i = 1'b0;
        cyc(2);
        check("rst", {pend, ctrl}, 9'h001);
        check("rst", {sda_oe, cfg}, 9'h000);
        check("sdao", {8'h00, sda_o}, 9'h000);
        // Read with no pointer set, last byte refused
        host_u.start;
        xb(8'hd7, 1'b1, 9'h0d7);
        for (i = 0; i < 5; i = i + 1) begin
            m = (i == 0) ? 8'h5a : (i == 1) ? 8'h09 : (i == 4) ? 8'hfe : 8'h00;
            xb(8'hff, i == 4, {i == 4, m});
        end
        host_u.stop;
        // Foreign address gets no acknowledge
        host_u.start;
        xb(8'hd4, 1'b1, 9'h1d4);
        host_u.stop;
        // Random values through the control, bus config and ship registers
        for (i = 0; i < 3; i = i + 1) begin
            a = (i == 0) ? 8'h05 : (i == 1) ? 8'h40 : 8'h51;
            rnd = lfsr(rnd);
            m = (i == 0) ? rnd[7:0] & 8'h7f : rnd[7:0];
            wr(a, rnd[7:0]);
            rd(a, m);
            check("out", {1'b0, (i == 0) ? ctrl : (i == 1) ? cfg : ship}, {1'b0, m});
        end
        // Two data bytes in one write
        rnd = lfsr(rnd);
        host_u.start;
        xb(8'hd6, 1'b1, 9'h0d6);
        xb(8'h04, 1'b1, 9'h004);
        xb(rnd[7:0], 1'b1, {1'b0, rnd[7:0]});
        xb(rnd[15:8], 1'b1, {1'b0, rnd[15:8]});
        host_u.stop;
        check("ptr", {1'b0, ctrl}, {1'b0, rnd[15:8] & 8'h7f});
        rd(8'h04, rnd[7:0]);
        wr(8'h00, 8'h33);
        rd(8'h00, 8'h5a);
        // Unmapped offset reads zero
        rd(8'h10, 8'h00);
        // Each fault: flag, reset class, mask, read clear
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h05, 8'h3c);
            flt[3 - i] = 1'b1;
            cyc(3);
            check("frst", {8'h00, flt_rst}, {8'h00, i != 3});
            flt[3 - i] = 1'b0;
            cyc(2);
            check("flt", {pend, ctrl}, {i == 3, (i == 3) ? 8'h3c : 8'h01});
            rd(8'h03, (i == 3) ? 8'h01 : 8'h10 << i);
            rd(8'h03, 8'h00);
            check("pend", {8'h00, pend}, 9'h000);
        end
        // Soft reset: zero write does nothing, nonzero resets
        wr(8'h05, 8'h3c);
        wr(8'h50, 8'h00);
        check("soft", {1'b0, ctrl}, 9'h03c);
        wr(8'h50, 8'h81);
        rd(8'h50, 8'h00);
        check("soft", {1'b0, ctrl}, 9'h001);
        // Supply loss clears a pending flag
        flt[0] = 1'b1;
        cyc(2);
        flt[0] = 1'b0;
        flt[4] = 1'b1;
        cyc(3);
        flt[4] = 1'b0;
        cyc(2);
        rd(8'h03, 8'h00);
        final_report;
    end
endmodule // test_i2c_top_system_registers
